// File: hw/flwf_pkg.sv
// constants shared by the byte-buffer level and alert logic
// assumes one clock, clk_sys at 25 MHz, and synchronous reset srst
//
// Functional notes
// - fill count readable; each write adds one byte, each read removes one.
// - in 512-byte mode the count's high bits also read from the control register.
// - almost-full flag set when free space is at or below the threshold.
// - almost-empty flag set when fill count is at or below the threshold.
// - one threshold serves both flags, from the top and from the bottom.
// - threshold is control bit 2 as high part, watermark register as low byte.
// - a write into a full buffer sets overflow and the error interrupt status.
// - almost-empty enable lets a rising almost-empty flag raise the interrupt pin.
// - almost-full enable lets a rising almost-full flag raise the interrupt pin.
// - writing 1 to flush resets pointers and clears the fill count.
// - buffer size is 512 when size-select is 0, 255 when it is 1.
package flwf_pkg;

  localparam int DATA_W = 8;
  localparam int PTR_W = 9;
  localparam int CNT_W = 10;
  localparam int MEM_DEPTH = 512;
  localparam int PADDR_W = 12;

  localparam logic [CNT_W-1:0] DEPTH_FULL = 10'h200;
  localparam logic [CNT_W-1:0] DEPTH_SMALL = 10'h0ff;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h02;
  localparam logic [7:0] IDX_WMARK = 8'h03;
  localparam logic [7:0] IDX_COUNT = 8'h04;
  localparam logic [7:0] IDX_DATA = 8'h05;
  localparam logic [7:0] IDX_IRQST = 8'h06;
  localparam logic [7:0] IDX_IRQEN = 8'h07;

  // control register fields
  localparam int CTRL_FLUSH = 0;
  localparam int CTRL_SIZE = 1;
  localparam int CTRL_WMHI = 2;
  localparam int CTRL_HI = 3;
  localparam int CTRL_LO = 4;
  localparam int CTRL_OVF = 5;
  localparam int CTRL_CNTHI = 6;

  // interrupt status and enable fields
  localparam int IRQ_N = 3;
  localparam int IRQ_ERR = 0;
  localparam int IRQ_LO = 1;
  localparam int IRQ_HI = 2;

  localparam logic CTRL_SIZE_RST = 1'b0;
  localparam logic CTRL_WMHI_RST = 1'b0;
  localparam logic [7:0] WMARK_RST = 8'h00;
  localparam logic [IRQ_N-1:0] IRQEN_RST = 3'h0;
  localparam logic [IRQ_N-1:0] IRQST_RST = 3'h0;

endpackage : flwf_pkg

// File: hw/flwf_mem.sv
// byte storage for the shared buffer, registered read data
// assumes one write port and one read port on clk_sys
`timescale 1ns/1ps
`default_nettype none
module flwf_mem
  import flwf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic we,
  input wire logic [PTR_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic [PTR_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData
);

  logic [DATA_W-1:0] mem [MEM_DEPTH];

  // forwarding keeps rdData equal to the head byte when it is written now
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[wrAddr] <= wrData;
    end
    if (we && (wrAddr == rdAddr)) begin
      rdData <= wrData;
    end else begin
      rdData <= mem[rdAddr];
    end
  end

endmodule : flwf_mem
`default_nettype wire

// File: hw/flwf_alert.sv
// almost-full and almost-empty comparators for the buffer level
// assumes count, size select and threshold are registered upstream
`timescale 1ns/1ps
`default_nettype none
module flwf_alert
  import flwf_pkg::*;
(
  input wire logic [CNT_W-1:0] count,
  input wire logic [CNT_W-1:0] depth,
  input wire logic [PTR_W-1:0] threshold,
  output logic almostFull,
  output logic almostEmpty
);

  logic [CNT_W-1:0] freeSpace;
  logic [CNT_W-1:0] thresholdWide;

  // clamp: a size change with more bytes stored than fit must not wrap
  assign freeSpace = (count >= depth) ? '0 : depth - count;
  assign thresholdWide = {1'b0, threshold};
  assign almostFull = freeSpace <= thresholdWide;
  assign almostEmpty = count <= thresholdWide;

endmodule : flwf_alert
`default_nettype wire

// File: hw/flwf_top.sv
// level, watermark and alert logic of the shared byte buffer
// assumes an APB master on clk_sys and a command engine on the sm ports
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module flwf_top
  import flwf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic smPushValid,
  input wire logic [DATA_W-1:0] smPushData,
  input wire logic smPopReq,
  output logic [DATA_W-1:0] smPopData,
  output logic smReady,
  output logic smEmpty,
  output logic smFull,
  output logic irq
);

  // ****************************************
  // helpers
  // ****************************************

  function automatic logic regIs(
    input logic [PADDR_W-1:0] a,
    input logic [7:0] idx
  );
    regIs = (a[PADDR_W-1:10] == 2'h0) && (a[1:0] == 2'h0) && (a[9:2] == idx);
  endfunction : regIs

  function automatic logic [PTR_W-1:0] ptrStep(
    input logic [PTR_W-1:0] ptr,
    input logic [CNT_W-1:0] depth
  );
    logic [CNT_W-1:0] last;
    last = depth - 10'h001;
    if ({1'b0, ptr} >= last) begin
      ptrStep = '0;
    end else begin
      ptrStep = ptr + 9'h001;
    end
  endfunction : ptrStep

  // ****************************************
  // state
  // ****************************************

  logic [CNT_W-1:0] count_q, count_d;
  logic [PTR_W-1:0] wrPtr_q, wrPtr_d;
  logic [PTR_W-1:0] rdPtr_q, rdPtr_d;
  logic sizeSel_q;
  logic wmHi_q;
  logic [7:0] wmLo_q;
  logic ovf_q, ovf_d;
  logic hiPrev_q, loPrev_q;
  logic [IRQ_N-1:0] irqSt_q, irqSt_d;
  logic [IRQ_N-1:0] irqEn_q;
  logic [31:0] prdata_q, prdata_d;

  // ****************************************
  // bus decode
  // ****************************************

  logic setup;
  logic done;
  logic hitCtrl, hitWmark, hitCount, hitData, hitIrqSt, hitIrqEn;
  logic mapped;
  logic wrDone;
  logic rdDone;

  assign setup = psel && !penable;
  assign done = psel && penable;
  assign hitCtrl = regIs(paddr, IDX_CTRL);
  assign hitWmark = regIs(paddr, IDX_WMARK);
  assign hitCount = regIs(paddr, IDX_COUNT);
  assign hitData = regIs(paddr, IDX_DATA);
  assign hitIrqSt = regIs(paddr, IDX_IRQST);
  assign hitIrqEn = regIs(paddr, IDX_IRQEN);
  assign mapped = hitCtrl | hitWmark | hitCount | hitData | hitIrqSt | hitIrqEn;
  assign wrDone = done && pwrite && mapped;
  assign rdDone = done && !pwrite && mapped;

  // read data is fetched in setup, so every access ends in one access cycle
  assign pready = 1'b1;
  assign pslverr = done && !mapped;
  assign prdata = prdata_q;

  // ****************************************
  // buffer traffic
  // ****************************************

  logic [CNT_W-1:0] depth;
  logic full;
  logic empty;
  logic hostPush, hostPop;
  logic smPush, smPop;
  logic push, pop;
  logic pushOk, popOk;
  logic flush;
  logic ovfEv;
  logic [DATA_W-1:0] pushData;
  logic [DATA_W-1:0] headByte;

  assign depth = sizeSel_q ? DEPTH_SMALL : DEPTH_FULL;
  assign full = count_q >= depth;
  assign empty = count_q == '0;

  // engine yields while the host addresses the data port
  assign smReady = !(psel && hitData);
  assign smEmpty = empty;
  assign smFull = full;
  assign smPopData = headByte;

  assign hostPush = done && pwrite && hitData;
  assign hostPop = done && !pwrite && hitData;
  assign smPush = smPushValid && smReady;
  assign smPop = smPopReq && smReady;
  assign push = hostPush || smPush;
  assign pop = hostPop || smPop;
  assign pushData = hostPush ? pwdata[DATA_W-1:0] : smPushData;

  assign flush = wrDone && hitCtrl && pwdata[CTRL_FLUSH];
  // flush wins over a same-cycle engine byte
  assign pushOk = push && !full && !flush;
  assign popOk = pop && !empty && !flush;
  assign ovfEv = push && full && !flush;

  always_comb begin
    count_d = count_q;
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    if (flush) begin
      count_d = '0;
      wrPtr_d = '0;
      rdPtr_d = '0;
    end else begin
      if (pushOk) begin
        wrPtr_d = ptrStep(wrPtr_q, depth);
      end
      if (popOk) begin
        rdPtr_d = ptrStep(rdPtr_q, depth);
      end
      if (pushOk && !popOk) begin
        count_d = count_q + 10'h001;
      end else if (popOk && !pushOk) begin
        count_d = count_q - 10'h001;
      end
    end
  end

  flwf_mem u_mem (
    .clk_sys(clk_sys),
    .we(pushOk),
    .wrAddr(wrPtr_q),
    .wrData(pushData),
    .rdAddr(rdPtr_d),
    .rdData(headByte)
  );

  // ****************************************
  // alerts
  // ****************************************

  logic [PTR_W-1:0] threshold;
  logic almost_full_flag;
  logic almost_empty_flag;
  logic hiRise;
  logic loRise;

  // the high threshold bit still counts in 255-byte mode
  assign threshold = {wmHi_q, wmLo_q};

  // combinational from the count, so flags track every push, pop and flush
  flwf_alert u_alert (
    .count(count_q),
    .depth(depth),
    .threshold(threshold),
    .almostFull(almost_full_flag),
    .almostEmpty(almost_empty_flag)
  );

  assign hiRise = almost_full_flag && !hiPrev_q;
  assign loRise = almost_empty_flag && !loPrev_q;

  // ****************************************
  // interrupt status
  // ****************************************

  logic [IRQ_N-1:0] irqEv;
  logic [IRQ_N-1:0] irqClr;
  logic stRead;

  assign irqEv[IRQ_ERR] = ovfEv;
  assign irqEv[IRQ_LO] = loRise;
  assign irqEv[IRQ_HI] = hiRise;
  assign stRead = rdDone && hitIrqSt;
  // only bits the reader actually saw are cleared
  assign irqClr = stRead ? prdata_q[IRQ_N-1:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_N; gi++) begin : g_st
      // set wins over the read clear
      assign irqSt_d[gi] = irqEv[gi] | (irqSt_q[gi] & ~irqClr[gi]);
    end
  endgenerate

  assign irq = |(irqSt_q & irqEn_q);

  // flush wins: a push into a full buffer in the flush cycle does not set overflow
  assign ovf_d = ovfEv | (ovf_q & ~flush);

  // ****************************************
  // read mux
  // ****************************************

  logic [7:0] ctrlView;

  assign ctrlView = {count_q[CNT_W-1:8], ovf_q, almost_empty_flag, almost_full_flag,
                     wmHi_q, sizeSel_q, 1'b0};

  always_comb begin
    prdata_d = '0;
    if (hitCtrl) begin
      prdata_d[7:0] = ctrlView;
    end else if (hitWmark) begin
      prdata_d[7:0] = wmLo_q;
    end else if (hitCount) begin
      prdata_d[7:0] = count_q[7:0];
    end else if (hitData) begin
      prdata_d[DATA_W-1:0] = headByte;
    end else if (hitIrqSt) begin
      prdata_d[IRQ_N-1:0] = irqSt_q;
    end else if (hitIrqEn) begin
      prdata_d[IRQ_N-1:0] = irqEn_q;
    end
  end

  // ****************************************
  // registers
  // ****************************************

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count_q <= '0;
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      count_q <= count_d;
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sizeSel_q <= CTRL_SIZE_RST;
      wmHi_q <= CTRL_WMHI_RST;
    end else if (wrDone && hitCtrl) begin
      sizeSel_q <= pwdata[CTRL_SIZE];
      wmHi_q <= pwdata[CTRL_WMHI];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wmLo_q <= WMARK_RST;
    end else if (wrDone && hitWmark) begin
      wmLo_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irqEn_q <= IRQEN_RST;
    end else if (wrDone && hitIrqEn) begin
      irqEn_q <= pwdata[IRQ_N-1:0];
    end
  end

  // empty at reset, so almost-empty counts as already high
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hiPrev_q <= 1'b0;
      loPrev_q <= 1'b1;
      ovf_q <= 1'b0;
      irqSt_q <= IRQST_RST;
    end else begin
      hiPrev_q <= almost_full_flag;
      loPrev_q <= almost_empty_flag;
      ovf_q <= ovf_d;
      irqSt_q <= irqSt_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prdata_q <= '0;
    end else if (setup) begin
      prdata_q <= prdata_d;
    end
  end

endmodule : flwf_top
`default_nettype wire

// File: bench/flwf_chk_sva.sv
// port assertions for the buffer level and alert block
// assumes it is bound onto flwf_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module flwf_chk
  import flwf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic smPushValid,
  input wire logic smPopReq,
  input wire logic smReady,
  input wire logic smEmpty,
  input wire logic smFull,
  input wire logic irq
);
  wire logic [7:0] idx = paddr[9:2];
  // a control write may resize the buffer, so full is only held outside one
  wire logic ctrlWr = psel && penable && pwrite && paddr == {2'h0, IDX_CTRL, 2'h0};
  wire logic flushNow = ctrlWr && pwdata[CTRL_FLUSH];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ***
  // bus side
  // ***
  ready_always_a: assert property (pready) else $error("pready low");
  err_access_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  err_unmapped_a: assert property (psel && penable && idx < 8'h02 |-> pslverr)
    else $error("no pslverr");
  rdata_hold_a: assert property (!psel |=> $stable(prdata)) else $error("prdata moved");
  host_stall_a: assert property (smReady == !(psel && idx == IDX_DATA)) else $error("smReady");
  // ***
  // level side
  // ***
  push_fill_a: assert property (smReady && smPushValid && !smPopReq && !flushNow |=> !smEmpty)
    else $error("push lost");
  full_hold_a: assert property (smFull && smReady && smPushValid && !smPopReq && !ctrlWr
    |=> smFull) else $error("full dropped");
  empty_hold_a: assert property (smEmpty && smReady && smPopReq && !smPushValid |=> smEmpty)
    else $error("empty wrapped");
  flush_empty_a: assert property (flushNow |=> smEmpty && !smFull)
    else $error("flush kept data");
  irq_reset_a: assert property ($past(srst) |-> !irq) else $error("irq after reset");
endmodule : flwf_chk
bind flwf_top flwf_chk i_flwf_chk (
  .clk_sys(clk_sys),
  .srst(srst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .smPushValid(smPushValid),
  .smPopReq(smPopReq),
  .smReady(smReady),
  .smEmpty(smEmpty),
  .smFull(smFull),
  .irq(irq)
);
`default_nettype wire

// File: bench/flwf_eng.sv
// command engine model on the push/pop side of the buffer
// assumes tasks are called right after a rising clk_sys edge
`timescale 1ns/1ps
`default_nettype none
module flwf_eng
  import flwf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic smReady,
  output logic smPushValid,
  output logic [DATA_W-1:0] smPushData,
  output logic smPopReq
);
  initial begin
    smPushValid = 1'b0;
    smPushData = 8'h00;
    smPopReq = 1'b0;
  end
  // a request only counts at an edge where smReady is high
  task automatic push(input int n);
    int i;
    i = 0;
    smPushValid <= 1'b1;
    smPushData <= 8'h00;
    while (i < n) begin
      @(posedge clk_sys);
      if (smReady) begin
        i++;
        smPushData <= i[7:0];
      end
    end
    smPushValid <= 1'b0;
  endtask : push
  task automatic pop(input int n);
    int i;
    i = 0;
    smPopReq <= 1'b1;
    while (i < n) begin
      @(posedge clk_sys);
      if (smReady) begin
        i++;
      end
    end
    smPopReq <= 1'b0;
  endtask : pop
endmodule : flwf_eng
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the buffer level and alert block
// assumes APB with zero wait states allowed, engine model on sm ports
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import flwf_pkg::*;
  logic clk_sys, srst, psel, penable, pwrite, pready, pslverr;
  logic smPushValid, smPopReq, smReady, smEmpty, smFull, irq, errSeen;
  logic [PADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [DATA_W-1:0] smPushData, smPopData;
  int mismatches, n_compared;
  flwf_top i_flwf_top (
    .clk_sys(clk_sys),
    .srst(srst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .smPushValid(smPushValid),
    .smPushData(smPushData),
    .smPopReq(smPopReq),
    .smPopData(smPopData),
    .smReady(smReady),
    .smEmpty(smEmpty),
    .smFull(smFull),
    .irq(irq)
  );
  flwf_eng i_flwf_eng (
    .clk_sys(clk_sys),
    .smReady(smReady),
    .smPushValid(smPushValid),
    .smPushData(smPushData),
    .smPopReq(smPopReq)
  );
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // ***
  // shared tasks
  // ***
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdk(input logic [7:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0);
    chk("register", e, rd);
  endtask : rdk
  task automatic cnt(input logic [9:0] e);
    logic [31:0] c;
    apb(1'b0, IDX_CTRL, 32'h0);
    c = rd;
    apb(1'b0, IDX_COUNT, 32'h0);
    chk("count", {22'h0, e}, {22'h0, c[7:6], rd[7:0]});
  endtask : cnt
  task automatic irqIs(input logic e);
    repeat (2) @(posedge clk_sys);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask : irqIs
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  // ***
  // scenarios
  // ***
  task automatic t_reset;
    rdk(IDX_CTRL, 32'h10);
    rdk(IDX_WMARK, 32'h0);
    rdk(IDX_IRQEN, 32'h0);
    rdk(IDX_IRQST, 32'h0);
    apb(1'b1, 8'h01, 32'hff);
    chk("slverr", 32'h1, {31'h0, errSeen});
    apb(1'b1, IDX_COUNT, 32'h33);
    chk("slverr", 32'h0, {31'h0, errSeen});
    cnt(10'h000);
  endtask : t_reset
  task automatic t_host_data;
    apb(1'b1, IDX_DATA, 32'h5a);
    apb(1'b1, IDX_DATA, 32'ha5);
    cnt(10'h002);
    rdk(IDX_DATA, 32'h5a);
    cnt(10'h001);
    apb(1'b1, IDX_CTRL, 32'h01);
    cnt(10'h000);
    rdk(IDX_CTRL, 32'h10);
  endtask : t_host_data
  task automatic t_small;
    apb(1'b1, IDX_CTRL, 32'h02);
    apb(1'b1, IDX_WMARK, 32'h5a5aa504);
    rdk(IDX_WMARK, 32'h04);
    apb(1'b0, IDX_IRQST, 32'h0);
    apb(1'b1, IDX_IRQEN, 32'hfffffff9);
    i_flwf_eng.push(4);
    rdk(IDX_CTRL, 32'h12);
    i_flwf_eng.push(246);
    rdk(IDX_CTRL, 32'h02);
    i_flwf_eng.push(1);
    rdk(IDX_CTRL, 32'h0a);
    apb(1'b1, IDX_CTRL, 32'h06);
    rdk(IDX_CTRL, 32'h1e);
    i_flwf_eng.push(5);
    irqIs(1'b1);
    rdk(IDX_CTRL, 32'h3e);
    // raising the threshold made almost-empty rise as well
    rdk(IDX_IRQST, 32'h07);
    irqIs(1'b0);
  endtask : t_small
  task automatic t_big;
    apb(1'b1, IDX_CTRL, 32'h01);
    apb(1'b1, IDX_WMARK, 32'hc8);
    apb(1'b0, IDX_IRQST, 32'h0);
    apb(1'b1, IDX_IRQEN, 32'h4);
    i_flwf_eng.push(300);
    cnt(10'h12c);
    rdk(IDX_CTRL, 32'h40);
    i_flwf_eng.push(12);
    irqIs(1'b1);
    rdk(IDX_CTRL, 32'h48);
    rdk(IDX_IRQST, 32'h04);
    irqIs(1'b0);
    apb(1'b1, IDX_IRQEN, 32'h2);
    i_flwf_eng.pop(112);
    irqIs(1'b1);
    rdk(IDX_CTRL, 32'h10);
    rdk(IDX_IRQST, 32'h02);
    chk("head", 32'h70, {24'h0, smPopData});
  endtask : t_big
  task automatic t_mid_reset;
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    cnt(10'h000);
    rdk(IDX_CTRL, 32'h10);
    rdk(IDX_WMARK, 32'h0);
    rdk(IDX_IRQEN, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
  endtask : t_mid_reset
  task automatic t_empty_pop;
    apb(1'b1, IDX_CTRL, 32'h01);
    i_flwf_eng.pop(3);
    cnt(10'h000);
    apb(1'b1, IDX_DATA, 32'h77);
    cnt(10'h001);
    chk("head", 32'h77, {24'h0, smPopData});
    // push and pop in the same cycles leave the count unchanged
    fork
      i_flwf_eng.push(3);
      i_flwf_eng.pop(3);
    join
    cnt(10'h001);
    chk("head", 32'h02, {24'h0, smPopData});
  endtask : t_empty_pop
  initial begin
    #(40 * 20000);
    mismatches++;
    final_report();
  end
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    srst = 1'b1;
    mismatches = 0;
    n_compared = 0;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_host_data();
    t_small();
    t_big();
    t_mid_reset();
    t_empty_pop();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
